// File: rtl/mjp_defs.vh
// Register map, reset values and timing constants of the jog profiler
`ifndef MJP_DEFS_VH
`define MJP_DEFS_VH

// Register byte offsets (index = offset / 4)
`define MJP_IDX_CTRL      4'h0
`define MJP_IDX_INIT_VEL  4'h1
`define MJP_IDX_MAX_VEL   4'h2
`define MJP_IDX_ACC       4'h3
`define MJP_IDX_DEC       4'h4
`define MJP_IDX_AUTO_VEL  4'h5
`define MJP_IDX_INCH      4'h6
`define MJP_IDX_VEL_LIM   4'h7
`define MJP_IDX_STATUS    4'h8
`define MJP_IDX_PROF_SEL  4'h9
`define MJP_IDX_PROF_DATA 4'hA
`define MJP_IDX_CUR_VEL   4'hB

// Control fields
`define MJP_CTRL_MODE_LSB 0
`define MJP_CTRL_MOVE_LSB 2
`define MJP_MODE_OFF      2'h0
`define MJP_MODE_MANUAL   2'h1
`define MJP_MODE_AUTO     2'h2
`define MJP_MOVE_JOG      2'h0
`define MJP_MOVE_INCH     2'h1
`define MJP_MOVE_INCH_JOG 2'h2

// Profile field select codes
`define MJP_FLD_ACC       2'h0
`define MJP_FLD_DEC       2'h1
`define MJP_FLD_VEL       2'h2
`define MJP_FLD_POS       2'h3

// Reset values
`define MJP_RST_CTRL      4'h0
`define MJP_RST_INIT_VEL  32'h000003E8
`define MJP_RST_MAX_VEL   32'h00002710
`define MJP_RST_ACC       32'h00000FA0
`define MJP_RST_DEC       32'h00000FA0
`define MJP_RST_AUTO_VEL  32'h00000064
`define MJP_RST_INCH      32'h00000001
`define MJP_RST_VEL_LIM   32'h000186A0

// Timing
`define MJP_CLK_HZ        32'h017D7840
`define MJP_HOLD_MS       32'h000000C8
`define MJP_HOLD_CYC      (`MJP_HOLD_MS * (`MJP_CLK_HZ / 32'h000003E8))

`endif

// File: rtl/mjp_jog_profiler.v
// Single-axis jog, inching and auto-profile step pulse generator
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Jog type: start at initial velocity, accelerate to maximum velocity.
// - Jog type: on release decelerate at manual rate, then stop.
// - Inching type: emit inching-distance pulses at initial velocity.
// - Inching+jog: start at initial velocity; held past 200 ms, accelerate.
// - Inching+jog: on release decelerate to initial velocity, then stop.
// - Jog inputs act in manual mode; forward only also in auto.
// - Except in inching type, opposite jog input asserted while other held: decelerate to stop.
// - Newly asserted jog inputs are ignored while decelerating.
// - After a stop other than the end of inching, restart following whichever jog input is then on.
// - On entering manual, no new move starts until both jog inputs seen off.
// - Auto mode: forward jog rising edge advances to next profile.
// - Hold 256 profiles, indexed 0 to 255.
// - Profile holds accel, decel, velocity, target; readable and writable.
// - Second axis reads the same shared profile table.
// - Auto start: clamp profile rates and velocity to velocity limit.
// - Manual defaults 1000, 10000, 4000, 4000, each 32-bit.
// - Auto initial velocity is 32-bit, default 100.
// - Inching distance is 32-bit, default 1, sets pulse count.
// - Move-type field selects jog, inching or inching plus jog.
`include "mjp_defs.vh"

module mjp_jog_profiler #(
  parameter [31:0] HOLD_CYC = `MJP_HOLD_CYC
) (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_reset_n,
  // Wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [5:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg         o_wb_ack,
  output reg  [31:0] o_wb_dat,
  // Jog pins
  input  wire        i_jog_fwd_in,
  input  wire        i_jog_rev_in,
  // Drive outputs
  output reg         o_step,
  output reg         o_dir,
  output reg         o_busy,
  // Second axis profile read port
  input  wire [7:0]  i_axb_idx,
  input  wire [1:0]  i_axb_fld,
  output reg  [31:0] o_axb_data
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_DECEL = 3'h2;
  localparam [2:0] ST_INCH  = 3'h3;
  localparam [2:0] ST_HOLD  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and profile memory

  reg  [3:0]  ctrl_q;
  reg  [31:0] init_vel_q;
  reg  [31:0] max_vel_q;
  reg  [31:0] acc_q;
  reg  [31:0] dec_q;
  reg  [31:0] auto_vel_q;
  reg  [31:0] inch_q;
  reg  [31:0] vel_lim_q;
  reg  [9:0]  prof_sel_q;
  reg  [31:0] mem_acc [0:255];
  reg  [31:0] mem_dec [0:255];
  reg  [31:0] mem_vel [0:255];
  reg  [31:0] mem_pos [0:255];

  reg  [2:0]  st_q;
  reg  [31:0] vel_q;
  reg         armed_q;
  reg  [7:0]  cur_prof_q;
  reg  [31:0] rd_d;
  reg  [31:0] prof_rd;
  reg  [31:0] axb_d;

  wire        bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire [3:0]  widx    = i_wb_adr[5:2];
  wire        wr      = bus_req & i_wb_we;
  wire [7:0]  pidx    = prof_sel_q[7:0];
  wire [1:0]  pfld    = prof_sel_q[9:8];

  function [31:0] mjp_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      mjp_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          mjp_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // Byte-merged write values for the narrow registers
  wire [31:0] ctrl_m  = mjp_merge({28'h0, ctrl_q}, i_wb_dat, i_wb_sel);
  wire [31:0] psel_m  = mjp_merge({22'h0, prof_sel_q}, i_wb_dat, i_wb_sel);

  // Shared table: one selected word for software, one for the second axis
  always @* begin
    case (pfld)
      `MJP_FLD_ACC: prof_rd = mem_acc[pidx];
      `MJP_FLD_DEC: prof_rd = mem_dec[pidx];
      `MJP_FLD_VEL: prof_rd = mem_vel[pidx];
      default:      prof_rd = mem_pos[pidx];
    endcase
    case (i_axb_fld)
      `MJP_FLD_ACC: axb_d = mem_acc[i_axb_idx];
      `MJP_FLD_DEC: axb_d = mem_dec[i_axb_idx];
      `MJP_FLD_VEL: axb_d = mem_vel[i_axb_idx];
      default:      axb_d = mem_pos[i_axb_idx];
    endcase
  end

  always @* begin
    case (widx)
      `MJP_IDX_CTRL:      rd_d = {28'h0, ctrl_q};
      `MJP_IDX_INIT_VEL:  rd_d = init_vel_q;
      `MJP_IDX_MAX_VEL:   rd_d = max_vel_q;
      `MJP_IDX_ACC:       rd_d = acc_q;
      `MJP_IDX_DEC:       rd_d = dec_q;
      `MJP_IDX_AUTO_VEL:  rd_d = auto_vel_q;
      `MJP_IDX_INCH:      rd_d = inch_q;
      `MJP_IDX_VEL_LIM:   rd_d = vel_lim_q;
      `MJP_IDX_STATUS:    rd_d = {17'h0, st_q, 1'b0, armed_q, o_dir,
                                  o_busy, cur_prof_q};
      `MJP_IDX_PROF_SEL:  rd_d = {22'h0, prof_sel_q};
      `MJP_IDX_PROF_DATA: rd_d = prof_rd;
      `MJP_IDX_CUR_VEL:   rd_d = vel_q;
      default:            rd_d = 32'h0;
    endcase
  end

  // Profile storage has no reset; contents persist like backup memory
  always @(posedge i_sys_clk) begin
    if (wr && widx == `MJP_IDX_PROF_DATA) begin
      case (pfld)
        `MJP_FLD_ACC: mem_acc[pidx] <= mjp_merge(prof_rd, i_wb_dat, i_wb_sel);
        `MJP_FLD_DEC: mem_dec[pidx] <= mjp_merge(prof_rd, i_wb_dat, i_wb_sel);
        `MJP_FLD_VEL: mem_vel[pidx] <= mjp_merge(prof_rd, i_wb_dat, i_wb_sel);
        default:      mem_pos[pidx] <= mjp_merge(prof_rd, i_wb_dat, i_wb_sel);
      endcase
    end
    o_axb_data <= axb_d;
  end

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack   <= 1'b0;
      o_wb_dat   <= 32'h0;
      ctrl_q     <= `MJP_RST_CTRL;
      init_vel_q <= `MJP_RST_INIT_VEL;
      max_vel_q  <= `MJP_RST_MAX_VEL;
      acc_q      <= `MJP_RST_ACC;
      dec_q      <= `MJP_RST_DEC;
      auto_vel_q <= `MJP_RST_AUTO_VEL;
      inch_q     <= `MJP_RST_INCH;
      vel_lim_q  <= `MJP_RST_VEL_LIM;
      prof_sel_q <= 10'h0;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_req ? rd_d : 32'h0;
      if (wr) begin
        case (widx)
          `MJP_IDX_CTRL:     ctrl_q <= ctrl_m[3:0];
          `MJP_IDX_INIT_VEL: init_vel_q <= mjp_merge(init_vel_q, i_wb_dat,
                                                     i_wb_sel);
          `MJP_IDX_MAX_VEL:  max_vel_q <= mjp_merge(max_vel_q, i_wb_dat,
                                                    i_wb_sel);
          `MJP_IDX_ACC:      acc_q <= mjp_merge(acc_q, i_wb_dat, i_wb_sel);
          `MJP_IDX_DEC:      dec_q <= mjp_merge(dec_q, i_wb_dat, i_wb_sel);
          `MJP_IDX_AUTO_VEL: auto_vel_q <= mjp_merge(auto_vel_q, i_wb_dat,
                                                     i_wb_sel);
          `MJP_IDX_INCH:     inch_q <= mjp_merge(inch_q, i_wb_dat, i_wb_sel);
          `MJP_IDX_VEL_LIM:  vel_lim_q <= mjp_merge(vel_lim_q, i_wb_dat,
                                                    i_wb_sel);
          `MJP_IDX_PROF_SEL: prof_sel_q <= psel_m[9:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jog input synchronisers and mode tracking

  reg        fwd1_q;
  reg        fwd2_q;
  reg        fwd3_q;
  reg        rev1_q;
  reg        rev2_q;
  reg  [1:0] mode_prev_q;

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fwd1_q      <= 1'b0;
      fwd2_q      <= 1'b0;
      fwd3_q      <= 1'b0;
      rev1_q      <= 1'b0;
      rev2_q      <= 1'b0;
      mode_prev_q <= `MJP_MODE_OFF;
    end else begin
      fwd1_q      <= i_jog_fwd_in;
      fwd2_q      <= fwd1_q;
      fwd3_q      <= fwd2_q;
      rev1_q      <= i_jog_rev_in;
      rev2_q      <= rev1_q;
      mode_prev_q <= ctrl_q[1:0];
    end
  end

  wire [1:0] mode     = ctrl_q[`MJP_CTRL_MODE_LSB +: 2];
  wire [1:0] move     = ctrl_q[`MJP_CTRL_MOVE_LSB +: 2];
  wire       manual   = (mode == `MJP_MODE_MANUAL);
  wire       auto_m   = (mode == `MJP_MODE_AUTO);
  wire       man_in   = manual & (mode_prev_q != `MJP_MODE_MANUAL);
  wire       auto_in  = auto_m & (mode_prev_q != `MJP_MODE_AUTO);
  // Reverse input only counts in manual; forward counts in manual and auto; both dead in off
  wire       fwd      = (manual | auto_m) & fwd2_q;
  wire       rev      = manual & rev2_q;
  wire       fwd_rise = auto_m & fwd2_q & ~fwd3_q;
  wire       held     = o_dir ? fwd : rev;
  wire       opp      = o_dir ? rev : fwd;

  ////////////////////////////////////////////////////////////////////////////
  // Corrected auto profile, velocity ramp and pulse engine

  reg  [31:0] cor_acc_q;
  reg  [31:0] cor_dec_q;
  reg  [31:0] cor_vel_q;
  reg  [31:0] racc_q;
  reg  [31:0] ph_q;
  reg  [31:0] cnt_q;
  reg  [31:0] tmr_q;

  wire [7:0]  nidx    = auto_in ? 8'h00 : cur_prof_q + 8'h01;
  wire [31:0] up_rate = manual ? acc_q : cor_acc_q;
  wire [31:0] dn_rate = manual ? dec_q : cor_dec_q;
  wire [31:0] tgt     = manual ? max_vel_q : cor_vel_q;
  wire [31:0] vmin    = manual ? init_vel_q : auto_vel_q;
  wire        ramp_up = (st_q == ST_RUN) & (vel_q < tgt);
  wire        ramp_dn = (st_q == ST_DECEL) |
                        ((st_q == ST_RUN) & (vel_q > tgt));
  wire [32:0] rsum    = {1'b0, racc_q} + {1'b0, ramp_up ? up_rate : dn_rate};
  wire        rtick   = (ramp_up | ramp_dn) & (rsum >= {1'b0, `MJP_CLK_HZ});
  wire [32:0] psum    = {1'b0, ph_q} + {1'b0, vel_q};
  wire        pstep   = (st_q != ST_IDLE) & (psum >= {1'b0, `MJP_CLK_HZ});

  function [31:0] mjp_min;
    input [31:0] a;
    input [31:0] b;
    begin
      mjp_min = (a < b) ? a : b;
    end
  endfunction

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q       <= ST_IDLE;
      vel_q      <= 32'h0;
      armed_q    <= 1'b0;
      cur_prof_q <= 8'h00;
      cor_acc_q  <= 32'h0;
      cor_dec_q  <= 32'h0;
      cor_vel_q  <= 32'h0;
      racc_q     <= 32'h0;
      ph_q       <= 32'h0;
      cnt_q      <= 32'h0;
      tmr_q      <= 32'h0;
      o_step     <= 1'b0;
      o_dir      <= 1'b1;
      o_busy     <= 1'b0;
    end else begin
      o_step <= pstep;
      o_busy <= (st_q != ST_IDLE);
      // Level-sensitive arming after a mode change
      if (man_in) begin
        armed_q <= 1'b0;
      end else if (!fwd2_q && !rev2_q) begin
        armed_q <= 1'b1;
      end
      // Load profile with rates and velocity clamped to the limit
      if (auto_in || fwd_rise) begin
        cur_prof_q <= nidx;
        cor_acc_q  <= mjp_min(mem_acc[nidx], vel_lim_q);
        cor_dec_q  <= mjp_min(mem_dec[nidx], vel_lim_q);
        cor_vel_q  <= mjp_min(mem_vel[nidx], vel_lim_q);
      end
      // Ramp accumulator: one pps change per clock-rate of accumulated rate
      if (ramp_up | ramp_dn) begin
        racc_q <= rtick ? rsum[31:0] - `MJP_CLK_HZ : rsum[31:0];
        if (rtick && ramp_up) begin
          vel_q <= vel_q + 32'h1;
        end else if (rtick && vel_q != 32'h0) begin
          vel_q <= vel_q - 32'h1;
        end
      end else begin
        racc_q <= 32'h0;
      end
      // Phase accumulator for step timing
      if (st_q == ST_IDLE) begin
        ph_q <= 32'h0;
      end else begin
        ph_q <= pstep ? psum[31:0] - `MJP_CLK_HZ : psum[31:0];
      end
      case (st_q)
        ST_IDLE: begin
          // Arming from before the mode change must not start a move
          if (manual && armed_q && !man_in && (fwd ^ rev)) begin
            o_dir <= fwd;
            vel_q <= init_vel_q;
            tmr_q <= 32'h0;
            cnt_q <= inch_q;
            case (move)
              `MJP_MOVE_INCH:     st_q <= ST_INCH;
              `MJP_MOVE_INCH_JOG: st_q <= ST_HOLD;
              default:            st_q <= ST_RUN;
            endcase
          end else if (auto_m && !auto_in) begin
            o_dir <= 1'b1;
            vel_q <= auto_vel_q;
            st_q  <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (manual ? (!held || opp) : !auto_m) begin
            st_q <= ST_DECEL;
          end
        end
        ST_DECEL: begin
          // New jog inputs are not looked at here
          if (vel_q <= vmin) begin
            vel_q <= 32'h0;
            st_q  <= ST_IDLE;
          end
        end
        ST_INCH: begin
          if (cnt_q == 32'h0 || !manual) begin
            vel_q   <= 32'h0;
            st_q    <= ST_IDLE;
            armed_q <= 1'b0;
          end else if (pstep) begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        ST_HOLD: begin
          if (!manual || !held || opp) begin
            vel_q <= 32'h0;
            st_q  <= ST_IDLE;
          end else if (tmr_q >= HOLD_CYC - 32'h1) begin
            st_q <= ST_RUN;
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        default: begin
          vel_q <= 32'h0;
          st_q  <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: verif/mjp_jog_sva.sv
// Port-level assertions for the jog profiler
`timescale 1ns/100ps
module mjp_jog_sva (
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  // Bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [5:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  // Drive side
  input wire logic        o_step,
  input wire logic        o_dir,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Mode field as last written by software
  reg [1:0] mode_q;
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= 2'h0;
    end else if (o_wb_ack && i_wb_we && i_wb_adr[5:2] == 4'h0 &&
                 i_wb_sel[0]) begin
      mode_q <= i_wb_dat[1:0];
    end
  end
  a_ack_answer: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without a request");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  a_step_single: assert property (o_step |=> !o_step)
    else $error("step pulse wider than one cycle");
  a_step_busy: assert property (o_step |-> o_busy || $past(o_busy))
    else $error("step while engine idle");
  a_dir_steady: assert property (
    o_busy && $past(o_busy) |-> $stable(o_dir))
    else $error("direction changed during a move");
  a_off_quiet: assert property (
    mode_q == 2'h0 && !o_busy && !$past(o_busy) |-> !o_step)
    else $error("step pulse in off mode");
endmodule
bind mjp_jog_profiler mjp_jog_sva chk_u (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
  .o_wb_dat(o_wb_dat), .o_step(o_step), .o_dir(o_dir), .o_busy(o_busy)
);

// File: verif/mjp_drive_model.sv
// Motor drive model counting step pulses per direction
`timescale 1ns/100ps
module mjp_drive_model (
  // Clock
  input  wire logic i_clk,
  // Step and direction from the profiler
  input  wire logic i_step,
  input  wire logic i_dir,
  // Step totals
  output int        o_fwd_cnt,
  output int        o_rev_cnt
);
  // Counters are two-state and start at zero; direction taken per step
  always @(posedge i_clk) begin
    if (i_step === 1'h1 && i_dir === 1'h1) o_fwd_cnt <= o_fwd_cnt + 1;
    if (i_step === 1'h1 && i_dir === 1'h0) o_rev_cnt <= o_rev_cnt + 1;
  end
endmodule

// File: verif/mjp_jog_profiler_tb_top.sv
// Self-checking bench for the jog profiler
`timescale 1ns/100ps
module mjp_jog_profiler_tb_top;
  logic        clk, i_reset_n, cyc, stb, we, fwd, rev, ack, step, dir, busy;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, axb_data, q;
  logic [7:0]  axb_idx, pidx [4];
  logic [1:0]  axb_fld, pfld [4];
  logic [31:0] pdat [4];
  int          bad_count, checks, fwd_cnt, rev_cnt, c;
  logic [31:0] rst_v [6] = '{32'h3E8, 32'h2710, 32'hFA0, 32'hFA0,
                             32'h64, 32'h1};
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  mjp_jog_profiler #(.HOLD_CYC(32'h14)) dut_u (
    .i_sys_clk(clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_jog_fwd_in(fwd), .i_jog_rev_in(rev),
    .o_step(step), .o_dir(dir), .o_busy(busy), .i_axb_idx(axb_idx),
    .i_axb_fld(axb_fld), .o_axb_data(axb_data));
  mjp_drive_model drv_u (.i_clk(clk), .i_step(step), .i_dir(dir),
    .o_fwd_cnt(fwd_cnt), .o_rev_cnt(rev_cnt));
  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (ack !== 1'h1) begin
      bad_count++;
      end_of_test;
    end
  endtask
  task automatic pins(input logic f, r, input int cyc_n);
    @(posedge clk);
    fwd <= f;
    rev <= r;
    repeat (cyc_n) @(posedge clk);
  endtask
  // Waits for the engine to idle, then confirms no further steps
  task automatic wait_idle(input string nm);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'h0 && n < 5000);
    if (busy !== 1'h0) begin
      bad_count++;
      end_of_test;
    end
    c = fwd_cnt + rev_cnt;
    repeat (100) @(posedge clk);
    check(nm, fwd_cnt + rev_cnt, c);
  endtask
  initial begin
    {i_reset_n, cyc, stb, we, fwd, rev, adr, sel, wdat} = '0;
    {axb_idx, axb_fld, bad_count, checks} = '0;
    void'($urandom(36492));
    repeat (20) @(posedge clk);
    i_reset_n <= 1'h1;
    foreach (rst_v[i]) begin
      wb(6'(4 * (i + 1)), 1'h0, 32'h0);
      check("reset_value", q, rst_v[i]);
    end
    wb(6'h30, 1'h1, $urandom);
    wb(6'h30, 1'h0, 32'h0);
    check("unmapped", q, 32'h0);
    foreach (pidx[k]) begin
      pidx[k] = (k == 3) ? 8'hFF : 8'(k * 64) | 8'($urandom % 64);
      pfld[k] = 2'($urandom);
      pdat[k] = $urandom;
      wb(6'h24, 1'h1, {22'h0, pfld[k], pidx[k]});
      wb(6'h28, 1'h1, pdat[k]);
    end
    foreach (pidx[k]) begin
      wb(6'h24, 1'h1, {22'h0, pfld[k], pidx[k]});
      wb(6'h28, 1'h0, 32'h0);
      check("profile", q, pdat[k]);
      axb_idx <= pidx[k];
      axb_fld <= pfld[k];
      repeat (2) @(posedge clk);
      check("axis_b", axb_data, pdat[k]);
    end
    wb(6'h04, 1'h1, 32'h000F4240);
    wb(6'h08, 1'h1, 32'h000F4240);
    pins(1'h1, 1'h0, 200);
    check("off_mode", fwd_cnt, 0);
    wb(6'h00, 1'h1, 32'h1);
    repeat (200) @(posedge clk);
    check("not_armed", fwd_cnt, 0);
    pins(1'h0, 1'h0, 10);
    pins(1'h1, 1'h0, 300);
    check("jog_fwd", fwd_cnt >= 8 && rev_cnt == 0, 1);
    check("dir_fwd", dir, 1'h1);
    pins(1'h0, 1'h0, 0);
    wait_idle("jog_stop");
    pins(1'h0, 1'h1, 300);
    check("jog_rev", rev_cnt >= 8, 1);
    check("dir_rev", dir, 1'h0);
    pins(1'h1, 1'h1, 0);
    wait_idle("both_on");
    pins(1'h0, 1'h0, 10);
    wb(6'h18, 1'h1, 32'h3);
    wb(6'h00, 1'h1, 32'h5);
    c = fwd_cnt;
    pins(1'h1, 1'h0, 400);
    pins(1'h0, 1'h0, 10);
    check("inching", fwd_cnt - c, 3);
    wb(6'h00, 1'h1, 32'h9);
    c = fwd_cnt;
    pins(1'h1, 1'h0, 300);
    check("inch_jog", fwd_cnt - c >= 8, 1);
    pins(1'h0, 1'h0, 0);
    wait_idle("inch_jog_stop");
    wb(6'h00, 1'h1, 32'h2);
    wb(6'h20, 1'h0, 32'h0);
    check("auto_first", q[7:0], 8'h00);
    pins(1'h1, 1'h0, 10);
    pins(1'h0, 1'h0, 10);
    wb(6'h20, 1'h0, 32'h0);
    check("auto_next", q[7:0], 8'h01);
    // Leaving and re-entering auto must reload the first profile
    wb(6'h00, 1'h1, 32'h0);
    wb(6'h00, 1'h1, 32'h2);
    wb(6'h20, 1'h0, 32'h0);
    check("auto_reload", q[7:0], 8'h00);
    end_of_test;
  end
endmodule
